// ### include/irs_pkg.sv
// register map, fields, reset values and state codes.
// assumes one bus clock and a 3-bit register address.
package irs_pkg;

    // ==========================================================
    // register offsets
    localparam logic [2:0] REG_OWN_ADDR = 3'h0;
    localparam logic [2:0] REG_RATE = 3'h1;
    localparam logic [2:0] REG_CTRL = 3'h2;
    localparam logic [2:0] REG_TXDATA = 3'h3;
    localparam logic [2:0] REG_CMD = 3'h4;
    localparam logic [2:0] REG_STATUS = 3'h5;
    localparam logic [2:0] REG_IFLAG = 3'h6;
    localparam logic [2:0] REG_IMASK = 3'h7;

    // ==========================================================
    // reset values
    localparam logic [7:0] RST_OWN_ADDR = 8'h00;
    localparam logic [7:0] RST_RATE = 8'h00;
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_TXDATA = 8'h00;
    localparam logic [2:0] RST_IRQ = 3'h0;

    // ==========================================================
    // field positions
    localparam int ADDR_LSB = 1;       // slave address in bits 7..1
    localparam int MUL_MSB = 7;        // multiplier field bits 7..6
    localparam int MUL_LSB = 6;
    localparam int IDX_MSB = 5;        // rate index bits 5..0
    localparam int CTRL_EN = 0;
    localparam int CMD_START = 0;
    localparam int CMD_STOP = 1;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_ARB = 1;
    localparam int IRQ_ADDR = 2;

    // multiplier field codes
    localparam logic [1:0] MUL_X1 = 2'h0;
    localparam logic [1:0] MUL_X2 = 2'h1;
    localparam logic [1:0] MUL_X4 = 2'h2;

    // index of the last bit, the acknowledge slot, and the address bit count
    localparam logic [3:0] LAST_BIT = 4'h8;
    localparam logic [3:0] ADDR_BITS = 4'h7;

    // ==========================================================
    // master engine states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_START = 3'b001,
        ST_LOW = 3'b010,
        ST_HIGH = 3'b011,
        ST_STOP_LOW = 3'b100,
        ST_STOP_HIGH = 3'b101
    } irs_state_t;

endpackage

// ### src/irs_rate_lookup.sv
// rate index lookup: divider and three hold values.
// assumes a settled index; combinational.
module irs_rate_lookup
    import irs_pkg::*;
(
    input wire logic [5:0] rate_idx,
    output logic [11:0] scl_div,
    output logic [11:0] sda_hold,
    output logic [11:0] start_hold,
    output logic [11:0] stop_hold
);

    logic [47:0] ent;

    // ==========================================================
    // table: divider, data hold, start hold, stop hold
    always_comb begin // RQ3 RQ8
        unique case (rate_idx)
            6'h00: ent = {12'h014,12'h007,12'h006,12'h00B};
            6'h01: ent = {12'h016,12'h007,12'h007,12'h00C};
            6'h02: ent = {12'h018,12'h008,12'h008,12'h00D};
            6'h03: ent = {12'h01A,12'h008,12'h009,12'h00E};
            6'h04: ent = {12'h01C,12'h009,12'h00A,12'h00F};
            6'h05: ent = {12'h01E,12'h009,12'h00B,12'h010};
            6'h06: ent = {12'h022,12'h00A,12'h00D,12'h012};
            6'h07: ent = {12'h028,12'h00A,12'h010,12'h015};
            6'h08: ent = {12'h01C,12'h007,12'h00A,12'h00F};
            6'h09: ent = {12'h020,12'h007,12'h00C,12'h011};
            6'h0A: ent = {12'h024,12'h009,12'h00E,12'h013};
            6'h0B: ent = {12'h028,12'h009,12'h010,12'h015};
            6'h0C: ent = {12'h02C,12'h00B,12'h012,12'h017};
            6'h0D: ent = {12'h030,12'h00B,12'h014,12'h019};
            6'h0E: ent = {12'h038,12'h00D,12'h018,12'h01D};
            6'h0F: ent = {12'h044,12'h00D,12'h01E,12'h023};
            6'h10: ent = {12'h030,12'h009,12'h012,12'h019};
            6'h11: ent = {12'h038,12'h009,12'h016,12'h01D};
            6'h12: ent = {12'h040,12'h00D,12'h01A,12'h021};
            6'h13: ent = {12'h048,12'h00D,12'h01E,12'h025};
            6'h14: ent = {12'h050,12'h011,12'h022,12'h029};
            6'h15: ent = {12'h058,12'h011,12'h026,12'h02D};
            6'h16: ent = {12'h068,12'h015,12'h02E,12'h035};
            6'h17: ent = {12'h080,12'h015,12'h03A,12'h041};
            6'h18: ent = {12'h050,12'h009,12'h026,12'h029};
            6'h19: ent = {12'h060,12'h009,12'h02E,12'h031};
            6'h1A: ent = {12'h070,12'h011,12'h036,12'h039};
            6'h1B: ent = {12'h080,12'h011,12'h03E,12'h041};
            6'h1C: ent = {12'h090,12'h019,12'h046,12'h049};
            6'h1D: ent = {12'h0A0,12'h019,12'h04E,12'h051};
            6'h1E: ent = {12'h0C0,12'h021,12'h05E,12'h061};
            6'h1F: ent = {12'h0F0,12'h021,12'h076,12'h079};
            6'h20: ent = {12'h0A0,12'h011,12'h04E,12'h051};
            6'h21: ent = {12'h0C0,12'h011,12'h05E,12'h061};
            6'h22: ent = {12'h0E0,12'h021,12'h06E,12'h071};
            6'h23: ent = {12'h100,12'h021,12'h07E,12'h081};
            6'h24: ent = {12'h120,12'h031,12'h08E,12'h091};
            6'h25: ent = {12'h140,12'h031,12'h09E,12'h0A1};
            6'h26: ent = {12'h180,12'h041,12'h0BE,12'h0C1};
            6'h27: ent = {12'h1E0,12'h041,12'h0EE,12'h0F1};
            6'h28: ent = {12'h140,12'h021,12'h09E,12'h0A1};
            6'h29: ent = {12'h180,12'h021,12'h0BE,12'h0C1};
            6'h2A: ent = {12'h1C0,12'h041,12'h0DE,12'h0E1};
            6'h2B: ent = {12'h200,12'h041,12'h0FE,12'h101};
            6'h2C: ent = {12'h240,12'h061,12'h11E,12'h121};
            6'h2D: ent = {12'h280,12'h061,12'h13E,12'h141};
            6'h2E: ent = {12'h300,12'h081,12'h17E,12'h181};
            6'h2F: ent = {12'h3C0,12'h081,12'h1DE,12'h1E1};
            6'h30: ent = {12'h280,12'h041,12'h13E,12'h141};
            6'h31: ent = {12'h300,12'h041,12'h17E,12'h181};
            6'h32: ent = {12'h380,12'h081,12'h1BE,12'h1C1};
            6'h33: ent = {12'h400,12'h081,12'h1FE,12'h201};
            6'h34: ent = {12'h480,12'h0C1,12'h23E,12'h241};
            6'h35: ent = {12'h500,12'h0C1,12'h27E,12'h281};
            6'h36: ent = {12'h600,12'h101,12'h2FE,12'h301};
            6'h37: ent = {12'h780,12'h101,12'h3BE,12'h3C1};
            6'h38: ent = {12'h500,12'h081,12'h27E,12'h281};
            6'h39: ent = {12'h600,12'h081,12'h2FE,12'h301};
            6'h3A: ent = {12'h700,12'h101,12'h37E,12'h381};
            6'h3B: ent = {12'h800,12'h101,12'h3FE,12'h401};
            6'h3C: ent = {12'h900,12'h181,12'h47E,12'h481};
            6'h3D: ent = {12'hA00,12'h181,12'h4FE,12'h501};
            6'h3E: ent = {12'hC00,12'h201,12'h5FE,12'h601};
            6'h3F: ent = {12'hF00,12'h201,12'h77E,12'h781};
        endcase
    end

    // split the entry into its fields
    assign scl_div = ent[47:36];
    assign sda_hold = ent[35:24];
    assign start_hold = ent[23:12];
    assign stop_hold = ent[11:0];

endmodule // irs_rate_lookup

// ### src/irs_core.sv
// two-wire bus controller setup: own address, rate and hold timing,
// a byte-wide master engine, address watch and interrupts.
// assumes synchronous pins and open-drain pads.
//
// The implementer's own choices: the register offsets and the plain strobed port.

// How it works
// (RQ1) own address taken from bits 7..1
// (RQ2) multiplier codes 1, 2, 4, reserved
// (RQ3) rate index picks divider and holds
// (RQ4) clock period is multiplier times divider
// (RQ5) data changes after scaled data hold
// (RQ6) clock falls after scaled start hold
// (RQ7) data released after scaled stop hold
// (RQ8) fastest clock is bus clock over twenty
// (RQ9) runs and interrupts during wait mode
// (RQ10) light stop freezes, deep stop resets
// (RQ11) lines only driven low, else released
// (RQ12) lost arbitration drops to slave, interrupts
// (RQ13) delays counted in cycles, restart at edges
module irs_core
    import irs_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic wait_mode,
    input wire logic stop_light,
    input wire logic stop_deep,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    output logic irq
);

    // ==========================================================
    // declarations
    logic clr;
    logic run;
    logic [7:0] own_addr_q;
    logic [7:0] rate_q;
    logic [7:0] ctrl_q;
    logic [7:0] tx_q;
    logic [2:0] iflag_q;
    logic [2:0] imask_q;
    logic [7:0] rdata_q;
    logic irq_q;
    irs_state_t state_q;
    logic [15:0] cnt_q;
    logic [3:0] bit_q;
    logic [8:0] shift_q;
    logic scl_oe_q;
    logic sda_oe_q;
    logic stop_after_q;
    logic ack_q;
    logic master_q;
    logic ev_done;
    logic ev_arb;
    logic ev_addr;
    logic scl_p_q;
    logic sda_p_q;
    logic mon_act_q;
    logic bus_busy_q;
    logic [3:0] rx_cnt_q;
    logic [6:0] rx_q;
    logic [1:0] sh;
    logic [11:0] scl_div;
    logic [11:0] sda_hold;
    logic [11:0] start_hold;
    logic [11:0] stop_hold;
    logic [15:0] half_m;
    logic [15:0] sda_m;
    logic [15:0] start_m;
    logic [15:0] stop_m;
    logic cmd_go;
    logic scl_rise;
    logic start_seen;
    logic stop_seen;

    // deep stop resets all; light stop freezes
    assign clr = !rst_n || stop_deep; // RQ10
    assign run = ctrl_q[CTRL_EN] && !stop_light; // RQ10 RQ9

    // ==========================================================
    // rate selection
    irs_rate_lookup u_lookup (
        .rate_idx(rate_q[IDX_MSB:0]),
        .scl_div(scl_div),
        .sda_hold(sda_hold),
        .start_hold(start_hold),
        .stop_hold(stop_hold)
    );

    // multiplier as a shift; reserved code acts as one
    always_comb begin // RQ2
        unique case (rate_q[MUL_MSB:MUL_LSB])
            MUL_X2: sh = 2'h1;
            MUL_X4: sh = 2'h2;
            default: sh = 2'h0;
        endcase
    end

    // scaled counts; dividers are even so half a period is exact
    assign half_m = 16'({4'h0, scl_div} << sh) >> 1; // RQ4
    assign sda_m = 16'({4'h0, sda_hold} << sh); // RQ5
    assign start_m = 16'({4'h0, start_hold} << sh); // RQ6
    assign stop_m = 16'({4'h0, stop_hold} << sh); // RQ7

    // command taken only while idle
    assign cmd_go = reg_wr && reg_addr == REG_CMD && state_q == ST_IDLE && run;

    // ==========================================================
    // master engine
    always_ff @(posedge sys_clk) begin
        ev_done <= 1'b0;
        ev_arb <= 1'b0;
        if (clr) begin
            state_q <= ST_IDLE;
            cnt_q <= 16'h0000;
            bit_q <= 4'h0;
            shift_q <= 9'h1FF;
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
            stop_after_q <= 1'b0;
            ack_q <= 1'b0;
            master_q <= 1'b0;
        end else if (!ctrl_q[CTRL_EN]) begin
            state_q <= ST_IDLE;
            scl_oe_q <= 1'b0; // RQ11
            sda_oe_q <= 1'b0; // RQ11
            master_q <= 1'b0;
        end else if (run) begin
            unique case (state_q)
                ST_IDLE: begin
                    if (cmd_go) begin
                        shift_q <= {tx_q, 1'b1};
                        bit_q <= 4'h0;
                        cnt_q <= 16'h0000;
                        stop_after_q <= reg_wdata[CMD_STOP];
                        master_q <= 1'b1;
                        if (reg_wdata[CMD_START] || !master_q) begin
                            scl_oe_q <= 1'b0;
                            sda_oe_q <= 1'b0;
                            state_q <= ST_START;
                        end else begin
                            state_q <= ST_LOW;
                        end
                    end
                end
                ST_START: begin
                    // data falls with clock high, clock falls after hold
                    if (!sda_oe_q) begin
                        cnt_q <= 16'h0000;
                        if (scl_i) begin
                            sda_oe_q <= 1'b1;
                        end
                    end else if (cnt_q >= start_m - 16'h0001) begin
                        scl_oe_q <= 1'b1; // RQ6
                        cnt_q <= 16'h0000;
                        state_q <= ST_LOW;
                    end else begin
                        cnt_q <= cnt_q + 16'h0001; // RQ13
                    end
                end
                ST_LOW: begin
                    // data moves only after the data hold from the fall
                    if (cnt_q == sda_m) begin
                        sda_oe_q <= ~shift_q[8]; // RQ5 RQ11
                    end
                    if (cnt_q >= half_m - 16'h0001) begin
                        scl_oe_q <= 1'b0; // RQ4
                        cnt_q <= 16'h0000;
                        state_q <= ST_HIGH;
                    end else begin
                        cnt_q <= cnt_q + 16'h0001; // RQ13
                    end
                end
                ST_HIGH: begin
                    if (!scl_i) begin
                        cnt_q <= 16'h0000; // RQ13
                    end else if (bit_q != LAST_BIT && !sda_oe_q && !sda_i) begin
                        // another master pulled data low: back off as slave
                        scl_oe_q <= 1'b0; // RQ12
                        sda_oe_q <= 1'b0;
                        master_q <= 1'b0;
                        ev_arb <= 1'b1;
                        state_q <= ST_IDLE;
                    end else if (cnt_q >= half_m - 16'h0001) begin
                        scl_oe_q <= 1'b1; // RQ4
                        cnt_q <= 16'h0000;
                        if (bit_q == LAST_BIT) begin
                            ack_q <= !sda_i;
                            ev_done <= 1'b1;
                            state_q <= stop_after_q ? ST_STOP_LOW : ST_IDLE;
                        end else begin
                            bit_q <= bit_q + 4'h1;
                            shift_q <= {shift_q[7:0], 1'b1};
                            state_q <= ST_LOW;
                        end
                    end else begin
                        cnt_q <= cnt_q + 16'h0001; // RQ13
                    end
                end
                ST_STOP_LOW: begin
                    // pull data low under a low clock, then let clock rise
                    if (cnt_q == sda_m) begin
                        sda_oe_q <= 1'b1; // RQ5
                    end
                    if (cnt_q >= half_m - 16'h0001) begin
                        scl_oe_q <= 1'b0;
                        cnt_q <= 16'h0000;
                        state_q <= ST_STOP_HIGH;
                    end else begin
                        cnt_q <= cnt_q + 16'h0001;
                    end
                end
                ST_STOP_HIGH: begin
                    // data released only after the stop hold from the rise
                    if (!scl_i) begin
                        cnt_q <= 16'h0000; // RQ13
                    end else if (cnt_q >= stop_m - 16'h0001) begin
                        sda_oe_q <= 1'b0; // RQ7
                        master_q <= 1'b0;
                        state_q <= ST_IDLE;
                    end else begin
                        cnt_q <= cnt_q + 16'h0001;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // bus watch: start, stop and own-address match
    assign scl_rise = scl_i && !scl_p_q;
    assign start_seen = scl_i && scl_p_q && sda_p_q && !sda_i;
    assign stop_seen = scl_i && scl_p_q && !sda_p_q && sda_i;

    always_ff @(posedge sys_clk) begin
        ev_addr <= 1'b0;
        if (clr) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
            mon_act_q <= 1'b0;
            bus_busy_q <= 1'b0;
            rx_cnt_q <= 4'h0;
            rx_q <= 7'h00;
        end else if (run) begin
            scl_p_q <= scl_i;
            sda_p_q <= sda_i;
            if (start_seen) begin
                mon_act_q <= 1'b1;
                bus_busy_q <= 1'b1;
                rx_cnt_q <= 4'h0;
            end else if (stop_seen) begin
                mon_act_q <= 1'b0;
                bus_busy_q <= 1'b0;
            end else if (scl_rise && mon_act_q) begin
                rx_q <= {rx_q[5:0], sda_i};
                rx_cnt_q <= rx_cnt_q + 4'h1;
                if (rx_cnt_q == ADDR_BITS) begin
                    // eighth bit is direction; address sits above it
                    mon_act_q <= 1'b0;
                    if (!master_q && rx_q == own_addr_q[7:ADDR_LSB]) begin
                        ev_addr <= 1'b1; // RQ1
                    end
                end
            end
        end
    end

    // ==========================================================
    // software registers
    always_ff @(posedge sys_clk) begin
        if (clr) begin
            own_addr_q <= RST_OWN_ADDR; // RQ10
            rate_q <= RST_RATE;
            ctrl_q <= RST_CTRL;
            tx_q <= RST_TXDATA;
            imask_q <= RST_IRQ;
        end else if (reg_wr) begin
            unique case (reg_addr)
                REG_OWN_ADDR: own_addr_q <= {reg_wdata[7:ADDR_LSB], 1'b0}; // RQ1
                REG_RATE: rate_q <= reg_wdata;
                REG_CTRL: ctrl_q <= {7'h00, reg_wdata[CTRL_EN]};
                REG_TXDATA: tx_q <= reg_wdata;
                REG_IMASK: imask_q <= reg_wdata[2:0];
                default: ;
            endcase
        end
    end

    // sticky events; a new event wins over a same-cycle clear
    always_ff @(posedge sys_clk) begin
        if (clr) begin
            iflag_q <= RST_IRQ;
        end else begin
            iflag_q <= (iflag_q & ~((reg_wr && reg_addr == REG_IFLAG) ? reg_wdata[2:0] : 3'h0))
                | {ev_addr, ev_arb, ev_done}; // RQ12
        end
    end

    // read data the cycle after the strobe
    always_ff @(posedge sys_clk) begin
        if (clr) begin
            rdata_q <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                REG_OWN_ADDR: rdata_q <= own_addr_q;
                REG_RATE: rdata_q <= rate_q;
                REG_CTRL: rdata_q <= ctrl_q;
                REG_TXDATA: rdata_q <= tx_q;
                REG_CMD: rdata_q <= 8'h00;
                REG_STATUS: rdata_q <= {4'h0, bus_busy_q, ack_q, master_q,
                    state_q != ST_IDLE};
                REG_IFLAG: rdata_q <= {5'h00, iflag_q};
                REG_IMASK: rdata_q <= {5'h00, imask_q};
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end

    // level interrupt, also the wake source in wait mode
    always_ff @(posedge sys_clk) begin
        if (clr) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(iflag_q & imask_q); // RQ9
        end
    end

    // ==========================================================
    // outputs; pads only ever pull low
    assign scl_o = 1'b0 & wait_mode; // RQ11
    assign sda_o = 1'b0;
    assign scl_oe = scl_oe_q;
    assign sda_oe = sda_oe_q;
    assign reg_rdata = rdata_q;
    assign irq = irq_q;

endmodule // irs_core

// ### testbench/irs_properties.sv
// checker: line timing and register relations
// bound into irs_core; timing checks only at rate index 0
module irs_properties
    import irs_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic stop_light,
    input wire logic stop_deep,
    input wire logic scl_i,
    input wire logic scl_o,
    input wire logic scl_oe,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // rate shadow, factor, cycles since last line event
    logic [7:0] rate_q;
    logic [2:0] prev_q, ev_q, m;
    logic [15:0] cnt_q;
    assign m = (rate_q[7:6] == MUL_X2) ? 3'h2 : (rate_q[7:6] == MUL_X4) ? 3'h4 : 3'h1;
    // rate shadow, cleared like the block
    always_ff @(posedge sys_clk) begin
        if (!rst_n || stop_deep) begin
            rate_q <= RST_RATE;
        end else if (reg_wr && reg_addr == REG_RATE) begin
            rate_q <= reg_wdata;
        end
    end
    // which line signal moved last, and cycles since
    always_ff @(posedge sys_clk) begin
        prev_q <= {scl_oe, sda_oe, scl_i};
        if ({scl_oe, sda_oe, scl_i} != prev_q) begin
            ev_q <= {scl_oe, sda_oe, scl_i} ^ prev_q;
            cnt_q <= 16'h0001;
        end else begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end
    // ==========================================================
    // properties
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n || stop_deep);
    sequence start_edge_s;
        $rose(scl_oe) && sda_oe && ev_q == 3'b010 && rate_q[5:0] == 6'h00;
    endsequence
    sequence mask_off_s;
        reg_wr && reg_addr == REG_IMASK && reg_wdata == 8'h00 ##1 !(reg_wr && reg_addr == REG_IMASK);
    endsequence
    lines_low_a: assert property (!scl_o && !sda_o)
        else $error("a bus line is driven high");
    own_addr_read_a: assert property (reg_rd && reg_addr == REG_OWN_ADDR |=> !reg_rdata[0])
        else $error("own address bit 0 set");
    start_hold_a: assert property (start_edge_s |-> cnt_q == 6 * m)
        else $error("start hold wrong");
    high_phase_a: assert property ($rose(scl_oe) && ev_q == 3'b001 && rate_q[5:0] == 6'h00
        |-> cnt_q inside {[10 * m : 10 * m + 1]}) else $error("high phase wrong");
    data_hold_a: assert property ($changed(sda_oe) && scl_oe && ev_q == 3'b101
        && rate_q[5:0] == 6'h00 |-> cnt_q inside {[7 * m : 7 * m + 1]}) else $error("data hold wrong");
    stop_hold_a: assert property ($fell(sda_oe) && !scl_oe && ev_q == 3'b001
        && rate_q[5:0] == 6'h00 |-> cnt_q inside {[11 * m : 11 * m + 1]}) else $error("stop hold wrong");
    irq_masked_a: assert property (mask_off_s |=> !irq)
        else $error("irq up with mask off");
    light_freeze_a: assert property ($past(stop_light) |-> $stable(scl_oe) && $stable(sda_oe))
        else $error("lines move in light stop");
    deep_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        stop_deep |=> !scl_oe && !sda_oe && !irq && reg_rdata == 8'h00) else $error("deep stop no clear");
endmodule // irs_properties

bind irs_core irs_properties i_props (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .stop_light, .stop_deep, .scl_i, .scl_o, .scl_oe, .sda_o, .sda_oe, .irq);

// ### testbench/irs_bus_peer.sv
// bus far side: pull-ups, acknowledge, lost bit, clock stretch
// assumes a line is pulled low while its enable is high
module irs_bus_peer (
    input wire logic sys_clk,
    input wire logic scl_oe,
    input wire logic sda_oe,
    input wire logic ack_en,
    input wire logic lose,
    input wire logic [7:0] stretch,
    output logic scl_line,
    output logic sda_line
);
    timeunit 1ns;
    timeprecision 1ps;
    logic scl_q, sda_q;
    logic [3:0] falls_q = 4'hF;
    logic [7:0] hold_q = 8'h00;
    // wired lines: anyone may pull low, a released line goes high
    assign scl_line = !(scl_oe || hold_q != 8'h00);
    assign sda_line = !(sda_oe || (ack_en && falls_q == 4'h9) || (lose && falls_q == 4'h1));
    // count clock falls from each start; hold the clock low after each fall
    always_ff @(posedge sys_clk) begin
        scl_q <= scl_line;
        sda_q <= sda_line;
        if (scl_line && sda_q && !sda_line) begin
            falls_q <= 4'h0;
        end else if (scl_q && !scl_line) begin
            falls_q <= falls_q + 4'h1;
        end
        hold_q <= (scl_q && !scl_line) ? stretch : (hold_q != 8'h00) ? hold_q - 8'h01 : 8'h00;
    end
endmodule // irs_bus_peer

// ### testbench/irs_core_tb.sv
// bench: register access, one byte per multiplier code, lost bit, stop modes
// assumes the peer model and bound checker
module irs_core_tb
    import irs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, wait_mode = 1'b0;
    logic stop_light = 1'b0, stop_deep = 1'b0, ack_en = 1'b0, lose = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00, stretch = 8'h00, reg_rdata, v;
    logic scl_oe, sda_oe, scl_line, sda_line, irq;
    int err_count = 0, compares = 0, cycles = 0, m;
    // ==========================================================
    // clock, design and far side
    initial forever #5 sys_clk = ~sys_clk;
    irs_core i_dut (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .wait_mode, .stop_light, .stop_deep, .scl_i(scl_line), .scl_o(), .scl_oe,
        .sda_i(sda_line), .sda_o(), .sda_oe, .irq);
    irs_bus_peer i_peer (.sys_clk, .scl_oe, .sda_oe, .ack_en, .lose, .stretch, .scl_line,
        .sda_line);
    // ==========================================================
    // tasks
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic rd(input logic [2:0] a);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(posedge sys_clk);
        v = reg_rdata;
    endtask
    task automatic rdc(input logic [2:0] a, input logic [7:0] exp);
        rd(a);
        check(v, exp);
    endtask
    // start a byte, poll until idle
    task automatic xfer(input logic [7:0] cmd);
        wr(REG_CMD, cmd);
        v = 8'hFF;
        for (int n = 0; n < 800 && v[0] !== 1'b0; n++) rd(REG_STATUS);
    endtask
    task automatic close_out();
        $display("compares %0d, errors %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // hang guard
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            $display("Error at %0t: run did not finish", $time);
            close_out();
        end
    end
    // ==========================================================
    // test sequence
    initial begin
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        rdc(REG_RATE, RST_RATE);
        wr(REG_OWN_ADDR, 8'hA5);
        rdc(REG_OWN_ADDR, 8'hA4);
        wr(REG_RATE, 8'hFF);
        rdc(REG_RATE, 8'hFF);
        wr(REG_CTRL, 8'h01);
        wr(REG_IMASK, 8'h01);
        // each multiplier code; stretch, wait mode, no acknowledge
        for (m = 0; m < 4; m++) begin
            ack_en <= (m != 3);
            stretch <= (m == 1) ? 8'h28 : 8'h00;
            wait_mode <= (m == 2);
            wr(REG_RATE, {m[1:0], 6'h00});
            wr(REG_TXDATA, 8'hA6);
            xfer(8'h03);
            rdc(REG_STATUS, {5'h00, m != 3, 2'h0});
            rdc(REG_IFLAG, 8'h01);
            check({7'h00, irq}, 8'h01);
            wr(REG_IFLAG, 8'h01);
            rdc(REG_IFLAG, 8'h00);
            check({7'h00, irq}, 8'h00);
        end
        // lost first bit: back to slave, flag raised, then masked off
        wait_mode <= 1'b0;
        lose <= 1'b1;
        wr(REG_RATE, 8'h00);
        wr(REG_IMASK, 8'h02);
        xfer(8'h03);
        rd(REG_IFLAG);
        check(v & 8'h02, 8'h02);
        rd(REG_STATUS);
        check(v & 8'h02, 8'h00);
        check({7'h00, irq}, 8'h01);
        wr(REG_IMASK, 8'h00);
        @(posedge sys_clk);
        check({7'h00, irq}, 8'h00);
        lose <= 1'b0;
        wr(REG_IFLAG, 8'h07);
        // light stop keeps state, refuses a start; deep stop clears
        wr(REG_RATE, 8'h47);
        stop_light <= 1'b1;
        wr(REG_CMD, 8'h03);
        stop_light <= 1'b0;
        rd(REG_STATUS);
        check(v & 8'h01, 8'h00);
        rdc(REG_RATE, 8'h47);
        stop_deep <= 1'b1;
        @(posedge sys_clk);
        stop_deep <= 1'b0;
        @(posedge sys_clk);
        rdc(REG_RATE, RST_RATE);
        rdc(REG_OWN_ADDR, RST_OWN_ADDR);
        close_out();
    end
endmodule // irs_core_tb
